// ### rtl/wdog_pkg.sv
/*
 Package for the watchdog and deep-sleep wake-up block: register map, field
 positions, reset values, timing constants, the carrier struct and the power-state enum.
 Assumes a single 250 MHz core clock and a plain strobe register port.
*/
package wdog_pkg;

	localparam int CNT_W = 24;
	localparam int GPIO_N = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register offsets.
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_RELOAD = 4'h1;
	localparam logic [3:0] OFF_COUNT = 4'h2;
	localparam logic [3:0] OFF_STATUS = 4'h3;
	localparam logic [3:0] OFF_MASK = 4'h4;
	localparam logic [3:0] OFF_WAKE_EN = 4'h5;
	localparam logic [3:0] OFF_PORT_IN = 4'h6;

	// Control register fields.
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_TIMEOUT = 1;
	localparam int CTRL_SLEEP_WAKE = 2;

	// Status register fields.
	localparam int ST_TIMEOUT = 0;
	localparam int ST_WAKE = 1;
	localparam int ST_W = 2;

	// Reset values and limits.
	localparam logic [23:0] RELOAD_RST = 24'h00ffff;
	localparam logic [23:0] RELOAD_MIN = 24'h000004;
	localparam logic [23:0] CNT_MAX = 24'hffffff;

	// Glitch filter and recovery delay.
	localparam int CLK_PS = 4000;
	localparam int FILTER_PS = 10000;
	localparam int FILTER_CYC = (FILTER_PS + CLK_PS - 1) / CLK_PS;
	localparam int RECOVERY_NS = 400;
	localparam int RECOVERY_CYC = (RECOVERY_NS * 1000 + CLK_PS - 1) / CLK_PS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_RECOVER = 2'b10
	} pwr_state_t;

endpackage

// ### rtl/wdog_wake.sv
/*
 Watchdog down-counter with deep-sleep wake-up on GPIO edges or interrupt-mode time-out.
 Assumes the CPU refresh instruction, debug state and sleep entry arrive as
 same-clock signals, and that GPIO pins and the watchdog oscillator tick
 are asynchronous and are synchronised here.
*/
// Behaviour
// - An enabled GPIO pin changing level in either direction starts deep-sleep recovery.
// - GPIO wake edges shorter than about 10 ns are filtered out.
// - A GPIO wake sets the sleep-wake flag in the control register.
// - Port input data is frozen in sleep, sampled only at recovery end.
// - First enable loads the counter from the reload register.
// - The counter decrements on each oscillator tick unless refreshed.
// - Each refresh reloads the counter and counting resumes from there.
// - Debug mode keeps the watchdog refreshed continuously.
// - Zero count signals time-out; option bit picks reset or interrupt.
// - Interrupt-mode time-out requests an interrupt and sets the time-out flag.
// - After interrupt time-out the counter rolls to all ones, no reload.
// - Interrupt time-out in sleep starts recovery; both flags then read one.
// - Reload ranges from 4 to 16,777,215 counts.
`timescale 1ns/10ps
module wdog_wake #(
	parameter int GPIO_N = wdog_pkg::GPIO_N,
	parameter int RECOVERY_CYC = wdog_pkg::RECOVERY_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire wdog_pkg::reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	input wire logic refresh_instr,
	input wire logic debug_mode,
	input wire logic sleep_req,
	input wire logic timeout_response_select,
	input wire logic wdt_osc_tick,
	input wire logic [GPIO_N-1:0] gpio_pin,
	output logic [GPIO_N-1:0] port_input_data,
	output logic in_sleep,
	output logic wdt_irq,
	output logic wdt_sys_reset,
	output logic irq
);

	typedef struct packed {
		logic [GPIO_N-1:0] gpio_s1;
		logic [GPIO_N-1:0] gpio_s2;
		logic [GPIO_N-1:0] gpio_filt;
		logic [GPIO_N-1:0] gpio_cand;
		logic [3:0] filt_cnt;
		logic tick_s1;
		logic tick_s2;
		logic tick_d;
		logic enable;
		logic [23:0] reload;
		logic [23:0] count;
		logic watchdog_timeout_flag;
		logic sleep_wake_flag;
		logic [1:0] status;
		logic [1:0] mask;
		logic [GPIO_N-1:0] wake_en;
		logic [GPIO_N-1:0] port_in;
		wdog_pkg::pwr_state_t pwr;
		logic [15:0] rec_cnt;
		logic irq_o;
		logic sleep_o;
		logic wdt_irq_o;
		logic rst_o;
		logic [31:0] rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// Clamps a reload value to the legal lower bound.
	function automatic logic [23:0] clamp_reload(input logic [31:0] v);
		if (v[23:0] < wdog_pkg::RELOAD_MIN) begin
			return wdog_pkg::RELOAD_MIN;
		end
		return v[23:0];
	endfunction

	logic tick_edge;
	logic timeout;
	logic gpio_wake;
	logic [GPIO_N-1:0] filt_diff;
	logic wr_status;
	logic [1:0] ev;

	// Only the second synchroniser stage feeds logic; tick_d marks its rising edge.
	// A tick that stays high for many clocks therefore still counts a single step.
	assign tick_edge = st_r.tick_s2 & ~st_r.tick_d;
	// Time-out is taken on the step from one to zero, so the counter never rests at zero.
	// A refresh or a debug hold in the same cycle wins and no time-out is raised.
	assign timeout = st_r.enable && tick_edge && st_r.count == 24'h000001 && !refresh_instr
		&& !debug_mode;
	assign filt_diff = st_r.gpio_s2 ^ st_r.gpio_filt;
	assign gpio_wake = (st_r.pwr == wdog_pkg::PWR_SLEEP)
		&& |((st_r.gpio_cand ^ st_r.gpio_filt) & st_r.wake_en)
		&& st_r.filt_cnt == 4'(wdog_pkg::FILTER_CYC);
	assign wr_status = reg_req.wr && reg_req.addr == wdog_pkg::OFF_STATUS;
	assign ev = {gpio_wake, timeout && timeout_response_select};

	// Next-state logic for the whole block.
	always_comb begin
		st_nxt = st_r;
		st_nxt.gpio_s1 = gpio_pin;
		st_nxt.gpio_s2 = st_r.gpio_s1;
		st_nxt.tick_s1 = wdt_osc_tick;
		st_nxt.tick_s2 = st_r.tick_s1;
		st_nxt.tick_d = st_r.tick_s2;
		st_nxt.rst_o = 1'b0;
		st_nxt.rdata = 32'h0000_0000;

		// Pins must hold a new level for the filter time before it counts.
		// A pulse shorter than the filter resets the count and never reaches wake logic.
		// The cost is a fixed wake latency of a few clocks after the synchroniser.
		if (filt_diff == '0 || st_r.gpio_s2 != st_r.gpio_cand) begin
			st_nxt.filt_cnt = 4'h0;
			st_nxt.gpio_cand = st_r.gpio_s2;
		end else if (st_r.filt_cnt != 4'(wdog_pkg::FILTER_CYC)) begin
			st_nxt.filt_cnt = st_r.filt_cnt + 4'h1;
		end else begin
			st_nxt.gpio_filt = st_r.gpio_cand;
			st_nxt.filt_cnt = 4'h0;
		end

		// Counter: refresh and debug beat the tick so no spurious time-out.
		if (st_r.enable) begin
			if (refresh_instr || debug_mode) begin
				st_nxt.count = st_r.reload;
			end else if (timeout) begin
				st_nxt.count = wdog_pkg::CNT_MAX;
				st_nxt.watchdog_timeout_flag = timeout_response_select
					| st_r.watchdog_timeout_flag;
				st_nxt.rst_o = ~timeout_response_select;
			end else if (tick_edge) begin
				st_nxt.count = st_r.count - 24'h000001;
			end
		end

		// Power state: sleep, then a fixed recovery delay before running.
		unique case (st_r.pwr)
			wdog_pkg::PWR_RUN: begin
				if (sleep_req) begin
					st_nxt.pwr = wdog_pkg::PWR_SLEEP;
				end
			end
			wdog_pkg::PWR_SLEEP: begin
				if (gpio_wake || (timeout && timeout_response_select)) begin
					st_nxt.pwr = wdog_pkg::PWR_RECOVER;
					st_nxt.sleep_wake_flag = 1'b1;
					st_nxt.rec_cnt = 16'h0000;
				end
			end
			wdog_pkg::PWR_RECOVER: begin
				if (st_r.rec_cnt == 16'(RECOVERY_CYC - 1)) begin
					st_nxt.pwr = wdog_pkg::PWR_RUN;
					st_nxt.port_in = st_r.gpio_s2;
				end else begin
					st_nxt.rec_cnt = st_r.rec_cnt + 16'h0001;
				end
			end
			default: st_nxt.pwr = wdog_pkg::PWR_RUN;
		endcase
		if (st_r.pwr == wdog_pkg::PWR_RUN) begin
			st_nxt.port_in = st_r.gpio_s2;
		end

		// Register writes; hardware events win over write-one-to-clear.
		// Software that clears a flag in the cycle of a new event must not lose the event.
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				wdog_pkg::OFF_CTRL: begin
					if (reg_req.wdata[wdog_pkg::CTRL_ENABLE] && !st_r.enable) begin
						st_nxt.count = st_r.reload;
					end
					st_nxt.enable = reg_req.wdata[wdog_pkg::CTRL_ENABLE];
					if (reg_req.wdata[wdog_pkg::CTRL_TIMEOUT] && !timeout) begin
						st_nxt.watchdog_timeout_flag = 1'b0;
					end
					if (reg_req.wdata[wdog_pkg::CTRL_SLEEP_WAKE]
						&& st_nxt.pwr != wdog_pkg::PWR_RECOVER) begin
						st_nxt.sleep_wake_flag = 1'b0;
					end
				end
				wdog_pkg::OFF_RELOAD: st_nxt.reload = clamp_reload(reg_req.wdata);
				wdog_pkg::OFF_MASK: st_nxt.mask = reg_req.wdata[1:0];
				wdog_pkg::OFF_WAKE_EN: st_nxt.wake_en = reg_req.wdata[GPIO_N-1:0];
				default: ;
			endcase
		end
		st_nxt.status = (st_r.status & ~(wr_status ? reg_req.wdata[1:0] : 2'b00)) | ev;

		// Read data, one cycle after the strobe.
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				wdog_pkg::OFF_CTRL: st_nxt.rdata = {29'h0, st_r.sleep_wake_flag,
					st_r.watchdog_timeout_flag, st_r.enable};
				wdog_pkg::OFF_RELOAD: st_nxt.rdata = {8'h00, st_r.reload};
				wdog_pkg::OFF_COUNT: st_nxt.rdata = {8'h00, st_r.count};
				wdog_pkg::OFF_STATUS: st_nxt.rdata = {30'h0, st_r.status};
				wdog_pkg::OFF_MASK: st_nxt.rdata = {30'h0, st_r.mask};
				wdog_pkg::OFF_WAKE_EN: st_nxt.rdata = 32'(st_r.wake_en);
				wdog_pkg::OFF_PORT_IN: st_nxt.rdata = 32'(st_r.port_in);
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		st_nxt.wdt_irq_o = timeout && timeout_response_select;
		st_nxt.irq_o = |(st_nxt.status & st_nxt.mask);
		// The sleep output is registered so that the pin comes straight from a flop.
		st_nxt.sleep_o = st_nxt.pwr != wdog_pkg::PWR_RUN;
	end

	// State register with synchronous reset and clock enable.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.reload <= wdog_pkg::RELOAD_RST;
			st_r.count <= wdog_pkg::RELOAD_RST;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign port_input_data = st_r.port_in;
	assign in_sleep = st_r.sleep_o;
	assign wdt_irq = st_r.wdt_irq_o;
	assign wdt_sys_reset = st_r.rst_o;
	assign irq = st_r.irq_o;

	// Refresh reloads the counter on the next enabled edge.
	a_refresh_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.enable && refresh_instr && !reg_req.wr |=> st_r.count == $past(st_r.reload))
		else $error("refresh did not reload counter");

	// Debug holds the counter at the reload value and no response leaves the block.
	a_debug_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.enable && debug_mode && !reg_req.wr
		|=> st_r.count == $past(st_r.reload) && !wdt_irq && !wdt_sys_reset)
		else $error("counter not held in debug");

	// An interrupt time-out rolls to all ones rather than reloading.
	a_int_rollover: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && timeout && timeout_response_select |=> st_r.count == 24'hffffff && wdt_irq)
		else $error("no roll-over after interrupt time-out");

	// The option bit low turns a time-out into a reset pulse only.
	a_reset_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && timeout && !timeout_response_select |=> wdt_sys_reset && !wdt_irq)
		else $error("reset response missing");

	// The time-out flag follows an interrupt time-out even against a clear.
	a_int_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && timeout && timeout_response_select |=> st_r.watchdog_timeout_flag)
		else $error("time-out flag not set");

	// An interrupt time-out in sleep starts recovery and marks the wake.
	a_sleep_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && timeout && timeout_response_select && st_r.pwr == wdog_pkg::PWR_SLEEP
		|=> st_r.sleep_wake_flag && st_r.pwr == wdog_pkg::PWR_RECOVER)
		else $error("sleep time-out did not wake");

	// A pin wake sets the sleep-wake flag while still inside recovery.
	a_gpio_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && gpio_wake |=> st_r.sleep_wake_flag && in_sleep)
		else $error("gpio wake lost");

	// Port data may not move while the block sleeps.
	a_port_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_r.pwr == wdog_pkg::PWR_SLEEP |=> $stable(port_input_data))
		else $error("port data changed in sleep");

	// The clamp keeps the reload at or above the legal minimum.
	a_reload_min: assert property (@(posedge core_clk) disable iff (!rst_n)
		st_r.reload >= 24'h000004)
		else $error("reload below minimum");

	// Turning the watchdog on loads the counter from the reload register.
	a_enable_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && reg_req.wr && reg_req.addr == wdog_pkg::OFF_CTRL
		&& reg_req.wdata[wdog_pkg::CTRL_ENABLE] && !st_r.enable
		|=> st_r.count == $past(st_r.reload))
		else $error("enable did not load counter");

	// One tick edge moves the counter down by exactly one.
	a_tick_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.enable && tick_edge && !timeout && !refresh_instr && !debug_mode
		&& !reg_req.wr |=> st_r.count == $past(st_r.count) - 24'h000001)
		else $error("counter did not step on tick");

	// Without a tick, refresh, debug or write the counter stands still.
	a_count_still: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !tick_edge && !refresh_instr && !debug_mode && !reg_req.wr
		|=> $stable(st_r.count))
		else $error("counter moved without a tick");

	// A low clock enable freezes every bit of state.
	a_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
		!clk_en |=> $stable(st_r))
		else $error("state moved with clock enable low");

	// A filtered pin change takes the block into recovery.
	a_pin_recover: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && gpio_wake |=> st_r.pwr == wdog_pkg::PWR_RECOVER)
		else $error("pin wake did not start recovery");

	// With no pin enabled and no time-out the block stays asleep.
	a_no_source: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.pwr == wdog_pkg::PWR_SLEEP && st_r.wake_en == '0 && !timeout
		|=> st_r.pwr == wdog_pkg::PWR_SLEEP)
		else $error("wake without a source");

	// A pin wake needs the candidate level held over the preceding clocks.
	a_filter_held: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && gpio_wake |-> $past(st_r.gpio_s2, 1) == st_r.gpio_cand
		&& $past(st_r.gpio_s2, 2) == st_r.gpio_cand)
		else $error("short pulse passed the filter");

	// Port data are captured from the pins at the end of recovery.
	a_recover_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.pwr == wdog_pkg::PWR_RECOVER && st_r.rec_cnt == 16'(RECOVERY_CYC - 1)
		|=> st_r.pwr == wdog_pkg::PWR_RUN && port_input_data == $past(st_r.gpio_s2))
		else $error("port data not captured at recovery end");

	// In run the port data follow the synchronised pins.
	a_run_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && st_r.pwr == wdog_pkg::PWR_RUN |=> port_input_data == $past(st_r.gpio_s2))
		else $error("port data not following pins");

	// The interrupt line mirrors the unmasked status bits.
	a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> irq == |(st_r.status & st_r.mask))
		else $error("interrupt line disagrees with status");

	// The sleep output tracks the power state.
	a_sleep_out: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> in_sleep == (st_r.pwr != wdog_pkg::PWR_RUN))
		else $error("sleep output disagrees with state");

	// The reset request is a single clock pulse.
	a_reset_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && wdt_sys_reset |=> !wdt_sys_reset)
		else $error("reset request longer than one clock");

endmodule

// ### dv/cpu_model.sv
/*
 Model of the CPU core and interrupt controller facing the watchdog.
 Assumes one core clock, a synchronous active-low reset and bench requests for refreshes.
*/
`timescale 1ns/10ps
module cpu_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic refresh_ask,
	input wire logic wdt_irq,
	input wire logic wdt_sys_reset,
	output logic refresh_instr,
	output int irq_cnt,
	output int rst_cnt
);
	// The refresh instruction issues one clock after the ask, as a fetched opcode would.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			refresh_instr <= 1'b0;
			irq_cnt <= 0;
			rst_cnt <= 0;
		end else begin
			refresh_instr <= refresh_ask;
			irq_cnt <= irq_cnt + int'(wdt_irq);
			rst_cnt <= rst_cnt + int'(wdt_sys_reset);
		end
	end
endmodule

// ### dv/watchdog_and_stop_wakeup_bench.sv
/*
 Self-checking bench for the watchdog and deep-sleep wake-up block.
 Assumes the register port of the package and a shortened recovery delay of 4 cycles.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s: expected %h seen %h", nm, e, g); end end
module watchdog_and_stop_wakeup_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	wdog_pkg::reg_req_t req = '0;
	logic refresh_ask = 1'b0;
	logic debug_mode = 1'b0;
	logic sleep_req = 1'b0;
	logic sel = 1'b0;
	logic clk_en = 1'b1;
	logic tick = 1'b0;
	logic [7:0] gpio = 8'h00;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [7:0] pin_data;
	logic refresh_instr, in_sleep, wdt_irq, wdt_sys_reset, irq;
	int irq_cnt, rst_cnt;
	int mismatches = 0;
	int checks = 0;
	int cycles = 0;

	wdog_wake #(.GPIO_N(8), .RECOVERY_CYC(4)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(req),
		.reg_rdata(rdata), .refresh_instr(refresh_instr), .debug_mode(debug_mode),
		.sleep_req(sleep_req), .timeout_response_select(sel), .wdt_osc_tick(tick),
		.gpio_pin(gpio), .port_input_data(pin_data), .in_sleep(in_sleep),
		.wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset), .irq(irq));
	cpu_model cpu (.core_clk(core_clk), .rst_n(rst_n), .refresh_ask(refresh_ask),
		.wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset), .refresh_instr(refresh_instr),
		.irq_cnt(irq_cnt), .rst_cnt(rst_cnt));

	// Free-running 250 MHz clock.
	always #2 core_clk = ~core_clk;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// A hung wait is cut short here and counts against the run.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge core_clk) req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk) req <= '0;
		#1 d = rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Each tick is held long enough for the two-flop synchroniser to see it.
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge core_clk) tick <= 1'b1;
			cyc(4);
			tick <= 1'b0;
			cyc(4);
		end
		cyc(3);
	endtask

	task automatic refresh();
		@(posedge core_clk) refresh_ask <= 1'b1;
		@(posedge core_clk) refresh_ask <= 1'b0;
		cyc(3);
	endtask

	task automatic sleep();
		@(posedge core_clk) sleep_req <= 1'b1;
		@(posedge core_clk) sleep_req <= 1'b0;
		cyc(2);
	endtask

	task automatic wait_wake();
		#1;
		for (int i = 0; i < 300 && in_sleep !== 1'b0; i++) begin
			@(posedge core_clk);
			#1;
		end
	endtask

	// Main sequence of scenarios.
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		rd(wdog_pkg::OFF_RELOAD);
		`CHK("reload", 32'h00ffff, d)
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count", 32'h00ffff, d)
		wr(wdog_pkg::OFF_RELOAD, 32'h2);
		rd(wdog_pkg::OFF_RELOAD);
		`CHK("reload clamp", 32'h4, d)
		wr(wdog_pkg::OFF_MASK, 32'h3);
		wr(wdog_pkg::OFF_RELOAD, 32'h6);
		wr(wdog_pkg::OFF_CTRL, 32'h1);
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count load", 32'h6, d)
		ticks(2);
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count down", 32'h4, d)
		refresh();
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count refresh", 32'h6, d)
		@(posedge core_clk) clk_en <= 1'b0;
		ticks(2);
		@(posedge core_clk) clk_en <= 1'b1;
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count frozen", 32'h6, d)
		@(posedge core_clk) debug_mode <= 1'b1;
		ticks(3);
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count debug", 32'h6, d)
		@(posedge core_clk) debug_mode <= 1'b0;
		sel <= 1'b1;
		ticks(6);
		rd(wdog_pkg::OFF_COUNT);
		`CHK("count roll", 32'hffffff, d)
		`CHK("irq requests", 1, irq_cnt)
		`CHK("irq line", 1'b1, irq)
		rd(wdog_pkg::OFF_CTRL);
		`CHK("ctrl flag", 32'h3, d)
		wr(wdog_pkg::OFF_STATUS, 32'h1);
		wr(wdog_pkg::OFF_CTRL, 32'h3);
		`CHK("irq cleared", 1'b0, irq)
		@(posedge core_clk) sel <= 1'b0;
		refresh();
		ticks(6);
		`CHK("reset requests", 1, rst_cnt)
		`CHK("no irq", 1, irq_cnt)
		wr(wdog_pkg::OFF_WAKE_EN, 32'h1);
		refresh();
		sleep();
		`CHK("asleep", 1'b1, in_sleep)
		@(posedge core_clk) gpio <= 8'h02;
		cyc(12);
		`CHK("masked pin", 1'b1, in_sleep)
		`CHK("frozen data", 8'h00, pin_data)
		@(posedge core_clk) gpio <= 8'h03;
		@(posedge core_clk) gpio <= 8'h02;
		cyc(12);
		`CHK("glitch", 1'b1, in_sleep)
		@(posedge core_clk) gpio <= 8'h03;
		wait_wake();
		`CHK("pin wake", 1'b0, in_sleep)
		`CHK("data at wake", 8'h03, pin_data)
		rd(wdog_pkg::OFF_CTRL);
		`CHK("sleep flag", 32'h5, d)
		wr(wdog_pkg::OFF_CTRL, 32'h7);
		wr(wdog_pkg::OFF_STATUS, 32'h3);
		@(posedge core_clk) sel <= 1'b1;
		refresh();
		sleep();
		ticks(6);
		wait_wake();
		`CHK("timeout wake", 1'b0, in_sleep)
		rd(wdog_pkg::OFF_CTRL);
		`CHK("both flags", 32'h7, d)
		`CHK("sleep irq", 2, irq_cnt)
		end_of_test();
	end
endmodule
